/* design/radio_cfg_defs.svh */
// register offsets, field positions, reset values and timing for the radio/cpu config bank
// assumes inclusion by bare name from design files
`ifndef RADIO_CFG_DEFS_SVH
`define RADIO_CFG_DEFS_SVH

// =====================================================================
// register byte offsets
`define OFF_PAYLOAD      8'h00
`define OFF_ADDR_WIDTH   8'h04
`define OFF_MATCH_ADDR   8'h08
`define OFF_CPU_CLOCK    8'h0C
`define OFF_STATUS       8'h10

// =====================================================================
// field positions
`define RXPW_LSB         0
`define TXPW_LSB         8
`define RXAW_LSB         0
`define TXAW_LSB         4
`define FREQ_LSB         0
`define SRC_BIT          2

// =====================================================================
// reset values
`define RXPW_RST         6'h20
`define TXPW_RST         6'h20
`define RXAW_RST         3'h4
`define TXAW_RST         3'h4
`define MATCH_RST        32'hE7E7E7E7
`define FREQ_RST         2'h0
`define SRC_RST          1'h0
`define TXAW_FOUR_BYTE   3'h4

// =====================================================================
// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// =====================================================================
// clock divide ratios from the 16 MHz source
`define DIV_4MHZ         6'h04
`define DIV_2MHZ         6'h08
`define DIV_1MHZ         6'h10
`define DIV_500KHZ       6'h20

`endif

/* design/radio_cfg_pkg.sv */
// types for the radio/cpu config bank
// assumes nothing beyond a SystemVerilog compiler
package radio_cfg_pkg;
    typedef enum logic [1:0] {
        FREQ_4MHZ,
        FREQ_2MHZ,
        FREQ_1MHZ,
        FREQ_500KHZ
    } freq_sel_type;
endpackage

/* design/clk_sel_if.sv */
// link between the register bank and the processor clock generator
// assumes both ends run on aclk
`timescale 1ns/10ps
interface clk_sel_if;
    logic [1:0] freq_sel;
    logic       src_direct;
    logic       cpu_clk_en;
    modport bank (output freq_sel, output src_direct, input cpu_clk_en);
    modport gen  (input freq_sel, input src_direct, output cpu_clk_en);
endinterface

/* design/cpu_clk_gen.sv */
// processor clock-enable generator from the selected divide ratio
// assumes aclk is the oscillator-rate reference clock
`timescale 1ns/10ps
`include "radio_cfg_defs.svh"
module cpu_clk_gen
    import radio_cfg_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    clk_sel_if.gen    sel
);
    logic [5:0] cnt_q;
    logic [5:0] div_ratio;
    logic       wrap;

    // =================================================================
    // divide ratio decode
    assign div_ratio = (sel.freq_sel == FREQ_4MHZ) ? `DIV_4MHZ :
                       (sel.freq_sel == FREQ_2MHZ) ? `DIV_2MHZ :
                       (sel.freq_sel == FREQ_1MHZ) ? `DIV_1MHZ :
                                                     `DIV_500KHZ;
    assign wrap = (cnt_q >= div_ratio - 6'h01);

    always_ff @(posedge aclk) begin
        if (!aresetn || wrap || sel.src_direct) begin
            cnt_q <= 6'h00;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // direct source bypasses the divider entirely
    assign sel.cpu_clk_en = aresetn && (sel.src_direct || wrap);

    direct_every_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sel.src_direct |-> sel.cpu_clk_en)
        else $error("direct source did not pass every cycle");
    div_4mhz_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!sel.src_direct && sel.freq_sel == 2'h0 && sel.cpu_clk_en) ##1
        (!sel.src_direct && sel.freq_sel == 2'h0)[*4] |-> sel.cpu_clk_en)
        else $error("4 MHz enable spacing wrong");
    div_space_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!sel.src_direct && sel.freq_sel == 2'h1 && sel.cpu_clk_en) ##1
        (!sel.src_direct && sel.freq_sel == 2'h1) |-> !sel.cpu_clk_en)
        else $error("2 MHz enable too early");
endmodule // cpu_clk_gen

/* design/radio_cpu_config_fields.sv */
// AXI4-Lite register bank holding radio payload/address fields and cpu clock select
// assumes a single aclk domain and an AXI4-Lite master outside
//
// Operation
// - rx payload length: 6 bits, direct byte count
// - tx payload length: 6 bits, resets 32
// - tx address width code 100 means four bytes
// - match address 32 bits, E7E7E7E7, width-limited match
// - freq select 2 bits: 00 4MHz, 10 1MHz, 11 500kHz
// - freq select 01 gives 2MHz
// - source select 0 uses frequency select
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "radio_cfg_defs.svh"
module radio_cpu_config_fields
    import radio_cfg_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output wire logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output wire logic        s_axi_wready,
    output wire logic [1:0]  s_axi_bresp,
    output wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output wire logic        s_axi_arready,
    output wire logic [31:0] s_axi_rdata,
    output wire logic [1:0]  s_axi_rresp,
    output wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] rx_packet_address,
    output wire logic        rx_address_match,
    output wire logic [5:0]  receive_payload_length,
    output wire logic [5:0]  transmit_payload_length,
    output wire logic [2:0]  transmit_address_bytes,
    output wire logic        cpu_clk_en
);
    clk_sel_if sel_if ();

    logic [5:0]  rxpw_q;
    logic [5:0]  txpw_q;
    logic [2:0]  rxaw_q;
    logic [2:0]  txaw_q;
    logic [31:0] match_q;
    logic [1:0]  freq_q;
    logic        src_q;
    logic        aw_held_q;
    logic [7:0]  awaddr_q;
    logic        w_held_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        match_hit_q;

    // =================================================================
    // byte-lane merge used for every writable word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `OFF_PAYLOAD || a == `OFF_ADDR_WIDTH || a == `OFF_MATCH_ADDR ||
               a == `OFF_CPU_CLOCK || a == `OFF_STATUS;
    endfunction

    // =================================================================
    // write channel
    wire         do_write = aw_held_q && w_held_q && !bvalid_q;
    wire [31:0]  w_payload = merge({18'h0, txpw_q, 2'h0, rxpw_q}, wdata_q, wstrb_q);
    wire [31:0]  w_awidth  = merge({25'h0, txaw_q, 1'h0, rxaw_q}, wdata_q, wstrb_q);
    wire [31:0]  w_match   = merge(match_q, wdata_q, wstrb_q);
    wire [31:0]  w_clock   = merge({29'h0, src_q, freq_q}, wdata_q, wstrb_q);
    wire         wr_ok     = mapped(awaddr_q) && awaddr_q != `OFF_STATUS;

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 8'h00;
        end else if (s_axi_awvalid && !aw_held_q) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
        end else if (s_axi_wvalid && !w_held_q) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // =================================================================
    // configuration fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxpw_q <= `RXPW_RST;
            txpw_q <= `TXPW_RST;
        end else if (do_write && awaddr_q == `OFF_PAYLOAD) begin
            rxpw_q <= w_payload[`RXPW_LSB +: 6];
            txpw_q <= w_payload[`TXPW_LSB +: 6];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rxaw_q <= `RXAW_RST;
            txaw_q <= `TXAW_RST;
        end else if (do_write && awaddr_q == `OFF_ADDR_WIDTH) begin
            rxaw_q <= w_awidth[`RXAW_LSB +: 3];
            txaw_q <= w_awidth[`TXAW_LSB +: 3];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_q <= `MATCH_RST;
        end else if (do_write && awaddr_q == `OFF_MATCH_ADDR) begin
            match_q <= w_match;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            freq_q <= `FREQ_RST;
            src_q  <= `SRC_RST;
        end else if (do_write && awaddr_q == `OFF_CPU_CLOCK) begin
            freq_q <= w_clock[`FREQ_LSB +: 2];
            src_q  <= w_clock[`SRC_BIT];
        end
    end

    // =================================================================
    // address match over the selected number of bytes
    wire [3:0] byte_eq;
    wire [3:0] byte_used;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            assign byte_eq[g]   = rx_packet_address[g*8 +: 8] == match_q[g*8 +: 8];
            assign byte_used[g] = rxaw_q > 3'(g);
        end
    endgenerate
    wire match_now = &(byte_eq | ~byte_used);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_hit_q <= 1'b0;
        end else begin
            match_hit_q <= match_now;
        end
    end

    assign rx_address_match        = match_hit_q;
    assign receive_payload_length  = rxpw_q;
    assign transmit_payload_length = txpw_q;
    assign transmit_address_bytes  = (txaw_q == `TXAW_FOUR_BYTE) ? 3'h4 : txaw_q;

    // =================================================================
    // read channel
    wire [31:0] rd_mux =
        (s_axi_araddr == `OFF_PAYLOAD)    ? {18'h0, txpw_q, 2'h0, rxpw_q} :
        (s_axi_araddr == `OFF_ADDR_WIDTH) ? {25'h0, txaw_q, 1'h0, rxaw_q} :
        (s_axi_araddr == `OFF_MATCH_ADDR) ? match_q :
        (s_axi_araddr == `OFF_CPU_CLOCK)  ? {29'h0, src_q, freq_q} :
        (s_axi_araddr == `OFF_STATUS)     ? {30'h0, sel_if.cpu_clk_en, match_hit_q} :
                                            32'h0;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // =================================================================
    // processor clock generator
    assign sel_if.freq_sel   = freq_q;
    assign sel_if.src_direct = src_q;
    assign cpu_clk_en        = sel_if.cpu_clk_en;

    cpu_clk_gen u_clk (
        .aclk    (aclk),
        .aresetn (aresetn),
        .sel     (sel_if.gen)
    );

    // =================================================================
    // checks
    txpw_reset_a: assert property (@(posedge aclk)
        !aresetn |=> transmit_payload_length == 6'h20)
        else $error("tx payload length not reset to 32");
    match_reset_a: assert property (@(posedge aclk)
        !aresetn |=> match_q == 32'hE7E7E7E7 && freq_q == 2'h0 && !src_q)
        else $error("match or clock fields not at reset value");
    rxpw_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_q == 8'h00 && wstrb_q[0] |=> rxpw_q == $past(wdata_q[5:0]))
        else $error("rx payload length write lost");
    txpw_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_q == 8'h00 && wstrb_q[1] |=> txpw_q == $past(wdata_q[13:8]))
        else $error("tx payload length write lost");
    txaw_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
        txaw_q == 3'h4 |-> transmit_address_bytes == 3'h4)
        else $error("tx address code 100 not four bytes");
    match_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rxaw_q == 3'h1 && rx_packet_address[7:0] == match_q[7:0] |=> rx_address_match)
        else $error("one-byte match missed");
    match_full_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rxaw_q == 3'h4 && rx_packet_address != match_q |=> !rx_address_match)
        else $error("four-byte mismatch reported as match");
    match_wide_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rxaw_q >= 3'h4 && rx_packet_address == match_q |=> rx_address_match)
        else $error("four-byte match missed");
    match_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_q == 8'h08 && wstrb_q == 4'hF |=> match_q == $past(wdata_q))
        else $error("match address write lost");
    fields_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !do_write |=> $stable(rxpw_q) && $stable(txpw_q) && $stable(match_q) &&
        $stable(freq_q) && $stable(src_q))
        else $error("configuration field changed without a write");
    freq_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_q == 8'h0C && wstrb_q[0] |=> freq_q == $past(wdata_q[1:0]))
        else $error("frequency select write lost");
    src_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_q == 8'h0C && wstrb_q[0] |=> src_q == $past(wdata_q[2]))
        else $error("clock source select write lost");

    // =================================================================
    // handshake checks
    resp_after_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");
    slverr_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && !wr_ok |=> s_axi_bresp == `RESP_SLVERR)
        else $error("refused write not answered with slave error");
    bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before taken");
    unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready && !mapped(s_axi_araddr) |=>
        s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule // radio_cpu_config_fields

/* testbench/radio_cpu_config_fields_bench.sv */
// self-checking bench for the radio/cpu config register bank
// assumes the design files under design/ are compiled first
`timescale 1ns/10ps
`include "radio_cfg_defs.svh"
module radio_cpu_config_fields_bench;
    import radio_cfg_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic [31:0] pkt_addr;
    logic        addr_match;
    logic [5:0]  rx_len;
    logic [5:0]  tx_len;
    logic [2:0]  tx_aw;
    logic        clk_en;
    int          mismatches;
    int          checks;

    radio_cpu_config_fields u_radio_cpu_config_fields (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_packet_address(pkt_addr), .rx_address_match(addr_match),
        .receive_payload_length(rx_len), .transmit_payload_length(tx_len),
        .transmit_address_bytes(tx_aw), .cpu_clk_en(clk_en)
    );

    // =====================================================================
    // clock and helpers
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task conclude;
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ready is sampled just before the edge that takes the item
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       aw_hit;
        logic       w_hit;
        logic       aw_done;
        logic       w_done;
        logic       b_seen;
        logic [1:0] resp;
        int         n;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_seen = 1'b0;
        resp = 2'h0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done) && n < 100) begin
            @(negedge aclk);
            aw_hit = !aw_done && awready;
            w_hit = !w_done && wready;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            aw_done = aw_done || aw_hit;
            w_done = w_done || w_hit;
            n++;
        end
        while (!b_seen && n < 200) begin
            @(negedge aclk);
            b_seen = bvalid;
            resp = bresp;
            @(posedge aclk);
            n++;
        end
        if (!b_seen) mismatches++;
        chk({30'h0, resp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic hit;
        int   n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            hit = arready;
            @(posedge aclk);
            n++;
        end while (!hit && n < 100);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            hit = rvalid;
            if (hit) begin
                chk(rdata, ed);
                chk({30'h0, rresp}, {30'h0, er});
            end
            @(posedge aclk);
            n++;
        end while (!hit && n < 200);
        if (!hit) mismatches++;
        rready <= 1'b0;
    endtask

    // cycles between two successive processor clock pulses
    task period(input int exp);
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (clk_en !== 1'b1 && n < 100);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (clk_en !== 1'b1 && n < 100);
        chk(n, exp);
    endtask

    task match(input logic [31:0] v, input logic exp);
        @(posedge aclk);
        pkt_addr <= v;
        @(posedge aclk);
        @(negedge aclk);
        chk({31'h0, addr_match}, {31'h0, exp});
    endtask

    // =====================================================================
    // tests
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        conclude;
    end

    initial begin
        mismatches = 0;
        checks = 0;
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        pkt_addr = 32'h0000_0000;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`OFF_PAYLOAD, 32'h0000_2020, `RESP_OKAY);
        rd(`OFF_ADDR_WIDTH, 32'h0000_0044, `RESP_OKAY);
        rd(`OFF_MATCH_ADDR, 32'hE7E7_E7E7, `RESP_OKAY);
        rd(`OFF_CPU_CLOCK, 32'h0000_0000, `RESP_OKAY);
        chk({26'h0, tx_len}, 32'h0000_0020);
        chk({29'h0, tx_aw}, 32'h0000_0004);
        // payload boundaries, upper bits read back as zero
        wr(`OFF_PAYLOAD, 32'hFFFF_2001, `RESP_OKAY);
        rd(`OFF_PAYLOAD, 32'h0000_2001, `RESP_OKAY);
        chk({26'h0, rx_len}, 32'h0000_0001);
        chk({26'h0, tx_len}, 32'h0000_0020);
        wr(`OFF_PAYLOAD, 32'h0000_0120, `RESP_OKAY);
        chk({26'h0, rx_len}, 32'h0000_0020);
        chk({26'h0, tx_len}, 32'h0000_0001);
        // address matching over one byte then four
        wr(`OFF_MATCH_ADDR, 32'h1122_3344, `RESP_OKAY);
        wr(`OFF_ADDR_WIDTH, 32'h0000_0041, `RESP_OKAY);
        chk({29'h0, tx_aw}, 32'h0000_0004);
        match(32'hAABB_CC44, 1'b1);
        match(32'hAABB_CC45, 1'b0);
        wr(`OFF_ADDR_WIDTH, 32'h0000_0044, `RESP_OKAY);
        match(32'hAABB_CC44, 1'b0);
        match(32'h1122_3344, 1'b1);
        match(32'h0122_3344, 1'b0);
        // every frequency code, then the divider bypass
        for (int c = 0; c < 4; c++) begin
            wr(`OFF_CPU_CLOCK, c, `RESP_OKAY);
            rd(`OFF_CPU_CLOCK, c, `RESP_OKAY);
            period(4 << c);
        end
        wr(`OFF_CPU_CLOCK, 32'h0000_0004, `RESP_OKAY);
        period(1);
        rd(`OFF_STATUS, 32'h0000_0002, `RESP_OKAY);
        wr(`OFF_CPU_CLOCK, 32'h0000_0000, `RESP_OKAY);
        period(4);
        // refused accesses leave the bank unchanged
        wr(8'h14, 32'h0000_3F3F, `RESP_SLVERR);
        rd(8'h14, 32'h0000_0000, `RESP_SLVERR);
        wr(`OFF_STATUS, 32'h0000_0003, `RESP_SLVERR);
        rd(`OFF_PAYLOAD, 32'h0000_0120, `RESP_OKAY);
        conclude;
    end
endmodule // radio_cpu_config_fields_bench
